// ### rtl/cwu_pkg.sv
// Package of register offsets, field positions and reset values for the waveform unit
package cwu_pkg;
  // Register byte offsets
  localparam logic [7:0] GENERATOR_CONTROL_0    = 8'h00;
  localparam logic [7:0] GENERATOR_CONTROL_1    = 8'h04;
  localparam logic [7:0] SHUTDOWN_CONTROL_0     = 8'h08;
  localparam logic [7:0] SHUTDOWN_SOURCE_SELECT = 8'h0C;
  localparam logic [7:0] STEERING_CONTROL       = 8'h10;
  localparam logic [7:0] INPUT_PIN_SELECT       = 8'h14;
  localparam logic [7:0] RISE_DEADBAND_COUNT    = 8'h18;
  localparam logic [7:0] FALL_DEADBAND_COUNT    = 8'h1C;
  localparam logic [7:0] RISE_BLANKING_COUNT    = 8'h20;
  localparam logic [7:0] FALL_BLANKING_COUNT    = 8'h24;
  localparam logic [7:0] RISE_PHASE_COUNT       = 8'h28;
  localparam logic [7:0] FALL_PHASE_COUNT       = 8'h2C;
  localparam logic [7:0] INT_STATUS             = 8'h30;
  localparam logic [7:0] INT_MASK               = 8'h34;
  localparam logic [7:0] UNIT_STATUS            = 8'h38;
  // generator_control_0 fields
  localparam int CTL0_EN    = 7;
  localparam int CTL0_LOAD  = 6;
  localparam int CTL0_CLKSEL = 3;
  // generator_control_1 fields
  localparam int CTL1_RISE_DEADBAND_CLOCK_SEL  = 7;
  localparam int CTL1_FALL_DEADBAND_CLOCK_SEL  = 6;
  localparam int CTL1_POL_A = 0;
  localparam int CTL1_POL_B = 1;
  // shutdown_control_0 fields
  localparam int ASD0_ACTIVE  = 7;
  localparam int ASD0_RESTART = 6;
  localparam int ASD0_OVR_B   = 2;
  localparam int ASD0_OVR_A   = 0;
  // input_pin_select: use field bits 1:0
  localparam logic [1:0] USE_RISE  = 2'h0;
  localparam logic [1:0] USE_FALL  = 2'h1;
  localparam logic [1:0] USE_FAULT = 2'h2;
  // Interrupt bit positions
  localparam int IRQ_LOADED = 0;
  localparam int IRQ_FAULT  = 1;
  localparam int IRQ_START  = 2;
  // Reset values and bus response codes
  localparam logic [7:0] ASD0_RESET = 8'h80;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cwu_pkg

// ### rtl/cwu_edge.sv
// Rising and falling edge detector for the selected event pin
`timescale 1ns/1ps
module cwu_edge (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in, edges out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev; // Level seen last cycle

  // Remember the previous level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev <= 1'b0;
    else
      prev <= level;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule : cwu_edge

// ### rtl/cwu_top.sv
// Complementary waveform unit: register file, buffers, start-up and output stage
// What this block does
// R01 - Disabled: count writes reach working buffers
// R02 - Enabled: count writes wait for load
// R03 - Load copies all counts together, synchronously
// R04 - Hardware clears load bit when done, unless a lane-0 write to another address lands that cycle
// R05 - One pin input: rise, fall, fault
// R06 - Keeps running in sleep while clocked
// R07 - Fast oscillator kept on in sleep when enabled and selected as clock
// R08 - Unit drives its own output enables
// R09 - Starts in shutdown; overrides set first
// R10 - Software sets shutdown, clears restart first
// R11 - Restart enable clears shutdown after enable
// R12 - Clearing shutdown after enable starts outputs
// R13 - Software picks deadbands and their clocks
// R14 - Steering bits programmed before enable
// R15 - Enable set only after configuration
// R16 - Load bit reads one until transfer done
`timescale 1ns/1ps
module cwu_top #(
  parameter int CW = 8 // Count width
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event pins and power state
  input  wire logic [3:0]  event_pins,
  input  wire logic        sleep_req,
  output logic             fast_internal_osc_keep,
  // Waveform outputs
  output logic             out_a,
  output logic             out_a_oe,
  output logic             out_b,
  output logic             out_b_oe,
  // Interrupt
  output logic             irq
);
  // Control registers
  logic [7:0]    generator_control_0;
  logic [7:0]    generator_control_1;
  logic [7:0]    shutdown_control_0;
  logic [7:0]    shutdown_source_select;
  logic [7:0]    steering_control;
  logic [7:0]    input_pin_select;
  logic [7:0]    int_status;
  logic [7:0]    int_mask;
  // Software-visible counts and working buffers, index 0..5
  logic [CW-1:0] count_reg [6];
  logic [CW-1:0] count_buf [6];
  // Bus handshake state
  logic          aw_held, w_held;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          do_write;
  // Waveform state
  logic          pin_level, ev_rise, ev_fall;
  logic          wave;
  logic [CW-1:0] delay_cnt;
  logic          enabled, active, fault;
  logic          load_now;

  // Count register index from address, or 7 outside offsets 0x18..0x2C
  function automatic logic [2:0] count_index(input logic [7:0] a);
    if (a >= cwu_pkg::RISE_DEADBAND_COUNT && a <= cwu_pkg::FALL_PHASE_COUNT)
      count_index = 3'((a - cwu_pkg::RISE_DEADBAND_COUNT) >> 2);
    else
      count_index = 3'h7;
  endfunction : count_index

  assign enabled = generator_control_0[cwu_pkg::CTL0_EN];
  assign active  = enabled & ~shutdown_control_0[cwu_pkg::ASD0_ACTIVE];

  // Accept address and data independently, one write at a time
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;

  // Write channel capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cwu_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > cwu_pkg::UNIT_STATUS || aw_addr[1:0] != 2'h0)
                      ? cwu_pkg::RESP_SLVERR : cwu_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control registers; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      generator_control_0    <= cwu_pkg::ZERO8;
      generator_control_1    <= cwu_pkg::ZERO8;
      shutdown_control_0     <= cwu_pkg::ASD0_RESET; // Start in shutdown [R09]
      shutdown_source_select <= cwu_pkg::ZERO8;
      steering_control       <= cwu_pkg::ZERO8;
      input_pin_select       <= cwu_pkg::ZERO8;
      int_mask               <= cwu_pkg::ZERO8;
    end
    else
    begin
      if (do_write && w_strb[0])
      begin
        case (aw_addr)
          cwu_pkg::GENERATOR_CONTROL_0:
            // Load bit only set by software, zero writes ignored [R16]
            generator_control_0 <= {w_data[7],
              w_data[6] | (generator_control_0[6] & ~load_now), w_data[5:0]};
          cwu_pkg::GENERATOR_CONTROL_1:    generator_control_1    <= w_data[7:0];
          cwu_pkg::SHUTDOWN_CONTROL_0:     shutdown_control_0     <= w_data[7:0];
          cwu_pkg::SHUTDOWN_SOURCE_SELECT: shutdown_source_select <= w_data[7:0];
          cwu_pkg::STEERING_CONTROL:       steering_control       <= w_data[7:0];
          cwu_pkg::INPUT_PIN_SELECT:       input_pin_select       <= w_data[7:0];
          cwu_pkg::INT_MASK:               int_mask               <= w_data[7:0];
          default: ;
        endcase
      end
      else if (load_now)
        generator_control_0[cwu_pkg::CTL0_LOAD] <= 1'b0; // Self-clear on transfer [R04]
      // Restart enable releases shutdown once running [R11]
      if (enabled && shutdown_control_0[cwu_pkg::ASD0_RESTART] && !fault)
        shutdown_control_0[cwu_pkg::ASD0_ACTIVE] <= 1'b0;
      else if (enabled && fault)
        shutdown_control_0[cwu_pkg::ASD0_ACTIVE] <= 1'b1;
    end
  end

  // Load happens on an event pin edge, or at once while not active, so all counts change together [R03]
  assign load_now = enabled & generator_control_0[cwu_pkg::CTL0_LOAD]
                    & (ev_rise | ev_fall | ~active);

  // Count registers and working buffers
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_cnt
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          count_reg[i] <= '0;
          count_buf[i] <= '0;
        end
        else
        begin
          if (do_write && w_strb[0] && count_index(aw_addr) == 3'(i))
            count_reg[i] <= w_data[CW-1:0];
          if (!enabled && do_write && w_strb[0] && count_index(aw_addr) == 3'(i))
            count_buf[i] <= w_data[CW-1:0]; // Direct while disabled [R01]
          else if (load_now)
            count_buf[i] <= count_reg[i];   // Held until load when enabled [R02] [R03]
        end
      end
    end
  endgenerate

  // Single pin input, routed by its use field [R05]
  assign pin_level = event_pins[input_pin_select[5:4]];
  assign fault = (input_pin_select[1:0] == cwu_pkg::USE_FAULT) & pin_level;

  cwu_edge u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (pin_level),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  // Waveform: phase delay then level, independent of sleep_req [R06]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wave      <= 1'b0;
      delay_cnt <= '0;
    end
    else if (!active)
    begin
      wave      <= 1'b0;
      delay_cnt <= '0;
    end
    else if (ev_rise && input_pin_select[1:0] == cwu_pkg::USE_RISE)
      delay_cnt <= count_buf[4] + CW'(1);
    else if (ev_fall && input_pin_select[1:0] == cwu_pkg::USE_FALL)
      wave <= 1'b0;
    else if (delay_cnt == CW'(1))
    begin
      wave      <= 1'b1;
      delay_cnt <= '0;
    end
    else if (delay_cnt != '0)
      delay_cnt <= delay_cnt - CW'(1);
  end

  // Output stage: overrides in shutdown, drivers on when enabled [R08] [R12]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_a_oe <= 1'b0;
      out_b_oe <= 1'b0;
    end
    else
    begin
      out_a_oe <= enabled;
      out_b_oe <= enabled;
      out_a <= active ? wave ^ generator_control_1[cwu_pkg::CTL1_POL_A]
                      : shutdown_control_0[cwu_pkg::ASD0_OVR_A]; // [R09]
      out_b <= active ? ~wave ^ generator_control_1[cwu_pkg::CTL1_POL_B]
                      : shutdown_control_0[cwu_pkg::ASD0_OVR_B];
    end
  end

  // Fast oscillator held on in sleep while it clocks the enabled unit [R07]
  assign fast_internal_osc_keep = enabled & sleep_req
                                  & (generator_control_0[4:3] == 2'h0);

  // Sticky interrupts; set wins over write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status <= cwu_pkg::ZERO8;
    else
    begin
      if (do_write && w_strb[0] && aw_addr == cwu_pkg::INT_STATUS)
        int_status <= int_status & ~w_data[7:0];
      if (load_now)
        int_status[cwu_pkg::IRQ_LOADED] <= 1'b1;
      if (enabled && fault)
        int_status[cwu_pkg::IRQ_FAULT] <= 1'b1;
      if (active && !shutdown_control_0[cwu_pkg::ASD0_ACTIVE] && ev_rise)
        int_status[cwu_pkg::IRQ_START] <= 1'b1;
    end
  end

  assign irq = |(int_status & int_mask);

  // Read channel, one cycle after address
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= cwu_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= cwu_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        cwu_pkg::GENERATOR_CONTROL_0:    s_axi_rdata[7:0] <= generator_control_0;
        cwu_pkg::GENERATOR_CONTROL_1:    s_axi_rdata[7:0] <= generator_control_1;
        cwu_pkg::SHUTDOWN_CONTROL_0:     s_axi_rdata[7:0] <= shutdown_control_0;
        cwu_pkg::SHUTDOWN_SOURCE_SELECT: s_axi_rdata[7:0] <= shutdown_source_select;
        cwu_pkg::STEERING_CONTROL:       s_axi_rdata[7:0] <= steering_control;
        cwu_pkg::INPUT_PIN_SELECT:       s_axi_rdata[7:0] <= input_pin_select;
        cwu_pkg::INT_STATUS:             s_axi_rdata[7:0] <= int_status;
        cwu_pkg::INT_MASK:               s_axi_rdata[7:0] <= int_mask;
        cwu_pkg::UNIT_STATUS:            s_axi_rdata[3:0] <= {fault, wave, active, enabled};
        default:
          if (count_index(s_axi_araddr) != 3'h7 && s_axi_araddr[1:0] == 2'h0)
            s_axi_rdata[CW-1:0] <= count_reg[count_index(s_axi_araddr)];
          else
            s_axi_rresp <= cwu_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : cwu_top

// ### tb/cwu_monitor.sv
// Port checker for the waveform unit, bound to the top module
`timescale 1ns/1ps
module cwu_monitor #(
  parameter int CW = 8 // Count width, kept in step with the unit
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Power state and outputs
  input wire logic        sleep_req,
  input wire logic        fast_internal_osc_keep,
  input wire logic        out_a_oe,
  input wire logic        out_b_oe,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers stand until taken
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
  // Answer timing
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  // No new request taken while an answer is pending
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  // Registers are eight bits wide
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Oscillator is only held on in sleep
  osc_keep_a: assert property (fast_internal_osc_keep |-> sleep_req)
    else $error("oscillator held outside sleep");
  // Both drivers enabled together
  oe_pair_a: assert property (out_a_oe == out_b_oe)
    else $error("driver enables differ");
  // Entering sleep does not stop the unit
  sleep_run_a: assert property ($rose(sleep_req) |=> $stable(out_a_oe))
    else $error("outputs stopped by sleep");

  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (fast_internal_osc_keep);
  cover property ($rose(irq));
endmodule : cwu_monitor

bind cwu_top cwu_monitor #(.CW(CW)) mon (.*);

// ### tb/cwu_partner.sv
// Event source model driving the unit's pin inputs
`timescale 1ns/1ps
module cwu_partner (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Commands from the bench
  input  wire logic       kick,
  input  wire logic [1:0] sel,
  input  wire logic [3:0] lag,
  // Levels into the unit
  output logic [3:0]      event_pins
);
  logic [4:0] cnt; // Cycles left before the edge
  logic       lvl; // Level of the chosen source

  // Delay a requested edge, prompt or slow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 5'h00;
      lvl <= 1'b0;
    end
    else if (kick)
      cnt <= {1'b0, lag} + 5'h01;
    else if (cnt != 5'h00)
    begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01)
        lvl <= ~lvl;
    end
  end

  // Other pins chatter each cycle, so a wrong pin pick shows up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_pins <= 4'h0;
    else
    begin
      event_pins      <= ~event_pins;
      event_pins[sel] <= lvl;
    end
  end
endmodule : cwu_partner

// ### tb/cwu_top_test.sv
// Self-checking bench for the waveform unit
`timescale 1ns/1ps
module cwu_top_test;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [3:0]  event_pins;
  logic        sleep_req     = 1'b0;
  logic        fast_internal_osc_keep;
  logic        out_a, out_a_oe, out_b, out_b_oe, irq;
  logic        kick          = 1'b0;
  logic [1:0]  sel           = 2'h0;
  logic [3:0]  lag           = 4'h0;
  logic [33:0] exp_q[$];     // Expected {resp, data} of reads
  logic [33:0] got;
  logic [7:0]  v;
  logic [7:0]  ph;            // Rise phase count written while disabled
  int          n;             // Edges counted until out_a rises
  logic [4:0]  outs;          // Watched levels, picked by index in chk
  localparam int K_OE  = 0;   // out_a_oe
  localparam int K_A   = 1;   // out_a
  localparam int K_B   = 2;   // out_b
  localparam int K_IRQ = 3;   // irq
  localparam int K_OSC = 4;   // fast_internal_osc_keep
  integer      seed          = 32'h7BE1;
  int          n_fail        = 0;
  int          total_checks  = 0;
  int          cyc           = 0;

  cwu_top #(.CW(8)) dut (.*);
  cwu_partner src (.*);

  // Read at the check time, not when chk is called
  assign outs = {fast_internal_osc_keep, irq, out_b, out_a, out_a_oe};

  // 125 MHz clock
  initial
  begin
    forever #4 aclk = ~aclk;
  end

  task automatic bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  // Bus write; ready for the answer only after it shows, to exercise holding
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = cwu_pkg::RESP_OKAY);
    logic ta;
    logic tw;
    begin
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(ta && tw))
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1 && !ta)
        begin
          ta = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready === 1'b1 && !tw)
        begin
          tw = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (s_axi_bvalid !== 1'b1)
        @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      total_checks++;
      if (s_axi_bresp !== r)
        bad("write response");
    end
  endtask : wr

  // Bus read; the watcher below compares the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = cwu_pkg::RESP_OKAY);
    begin
      exp_q.push_back({r, 24'h0, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
        @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
    end
  endtask : rd

  // Port level check, sampled mid-cycle so the level has settled
  task automatic chk(input int k, input logic e);
    @(negedge aclk);
    total_checks++;
    if (outs[k] !== e)
      bad("port level");
    @(posedge aclk);
  endtask : chk

  // Ask the partner for one edge on the chosen pin
  task automatic poke(input logic [3:0] l);
    lag  <= l;
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
  endtask : poke

  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Oldest expectation against each read answer
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      total_checks++;
      got = {s_axi_rresp, s_axi_rdata};
      if (exp_q.size() == 0 || got !== exp_q.pop_front())
        bad("read answer");
    end
  end

  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    sel = 2'($random(seed));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cwu_pkg::SHUTDOWN_CONTROL_0, cwu_pkg::ASD0_RESET);
    rd(cwu_pkg::GENERATOR_CONTROL_0, 8'h00);
    rd(8'h3C, 8'h00, cwu_pkg::RESP_SLVERR);
    wr(8'h3C, 8'h5A, cwu_pkg::RESP_SLVERR);
    // Configure fully while disabled
    wr(cwu_pkg::INPUT_PIN_SELECT, {2'h0, sel, 2'h0, cwu_pkg::USE_RISE});
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      if (i == 4)
      begin
        v[7] = 1'b0; // Short enough to time the phase delay below
        ph   = v;
      end
      wr(8'h18 + 8'(4 * i), v);
      rd(8'h18 + 8'(4 * i), v);
    end
    wr(cwu_pkg::GENERATOR_CONTROL_1, 8'hC0);
    wr(cwu_pkg::STEERING_CONTROL, 8'h0F);
    wr(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h85);
    wr(cwu_pkg::GENERATOR_CONTROL_0, 8'h80);
    rd(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h85);
    chk(K_OE, 1'b1);
    chk(K_A, 1'b1);
    chk(K_B, 1'b1);
    // Load while shut down completes at once; its event is masked, then unmasked
    wr(cwu_pkg::GENERATOR_CONTROL_0, 8'hC0);
    rd(cwu_pkg::GENERATOR_CONTROL_0, 8'h80);
    chk(K_IRQ, 1'b0);
    rd(cwu_pkg::INT_STATUS, 8'h01);
    wr(cwu_pkg::INT_MASK, 8'h01);
    chk(K_IRQ, 1'b1);
    wr(cwu_pkg::INT_STATUS, 8'h01);
    chk(K_IRQ, 1'b0);
    wr(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h05);
    rd(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h05);
    chk(K_A, 1'b0);
    chk(K_B, 1'b1);
    // Running loads: rising pin awake and prompt, falling pin asleep and slow
    for (int u = 0; u < 2; u++)
    begin
      wr(cwu_pkg::INPUT_PIN_SELECT, {2'h0, sel, 2'h0, 2'(u)});
      wr(cwu_pkg::RISE_PHASE_COUNT, 8'($random(seed)));
      wr(cwu_pkg::GENERATOR_CONTROL_0, 8'hC0);
      rd(cwu_pkg::GENERATOR_CONTROL_0, 8'hC0);
      wr(cwu_pkg::GENERATOR_CONTROL_0, 8'h80);
      rd(cwu_pkg::GENERATOR_CONTROL_0, 8'hC0);
      sleep_req <= u[0];
      poke(u[0] ? 4'hC : 4'h0);
      if (u == 0)
      begin
        // Edge reaches the unit three edges after the kick, then phase plus three
        n = 0;
        do
        begin
          @(posedge aclk);
          n++;
        end
        while (out_a !== 1'b1 && n < 300);
        total_checks++;
        if (n != int'(ph) + 6)
          bad("phase delay");
      end
      else
        repeat (20) @(posedge aclk);
      rd(cwu_pkg::GENERATOR_CONTROL_0, 8'h80);
      chk(K_OSC, u[0]);
      chk(K_A, ~u[0]);
    end
    wr(cwu_pkg::GENERATOR_CONTROL_0, 8'h88);
    chk(K_OSC, 1'b0);
    sleep_req <= 1'b0;
    // Fault on the pin, then auto-restart once it clears
    wr(cwu_pkg::INPUT_PIN_SELECT, {2'h0, sel, 2'h0, cwu_pkg::USE_FAULT});
    poke(4'h0);
    repeat (8) @(posedge aclk);
    rd(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h85);
    chk(K_A, 1'b1);
    poke(4'h3);
    repeat (8) @(posedge aclk);
    wr(cwu_pkg::SHUTDOWN_CONTROL_0, 8'hC5);
    repeat (4) @(posedge aclk);
    rd(cwu_pkg::SHUTDOWN_CONTROL_0, 8'h45);
    chk(K_A, 1'b0);
    chk(K_B, 1'b1);
    wrap_up();
  end
endmodule : cwu_top_test
